// *** logic/nvmcd_pkg.sv ***
// Package of the nonvolatile memory command dispatcher: register map, command codes,
// operation classes and the decode functions the dispatcher uses.
// Assumes a 32-bit APB slave port clocked by the 10 MHz bus clock.
package nvmcd_pkg;
   // Register byte addresses.
   localparam logic [7:0] REG_CMD  = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_PROT = 8'h08;
   localparam logic [7:0] REG_MRG  = 8'h0C;
   // Field positions.
   localparam int CMD_CODE_LSB  = 0;
   localparam int CMD_SEL_LSB   = 8;
   localparam int CMD_WCNT_LSB  = 10;
   localparam int CMD_PARAM_LSB = 16;
   localparam int STAT_COMMAND_COMPLETE_FLAG     = 7;
   localparam int STAT_ACCESS_ERROR_FLAG   = 5;
   localparam int STAT_PVIOL    = 4;
   localparam int STAT_VFAIL    = 0;
   localparam int PROT_LOW      = 0;
   localparam int PROT_HIGH     = 1;
   localparam int PROT_POPEN    = 2;
   localparam int PROT_DOPEN    = 3;
   localparam int MRG_ACT       = 2;
   localparam int MRG_PA_LSB    = 4;
   localparam int MRG_DA_LSB    = 8;
   // Reset values and encodings.
   localparam logic [3:0] PROT_RST      = 4'h0;
   localparam logic [3:0] PROT_ALL      = 4'hF;
   localparam logic [3:0] PROT_PA_FREE  = 4'h7;
   localparam logic [1:0] MARGIN_NORMAL = 2'h0;
   localparam logic [1:0] SEL_DATA      = 2'h0;
   localparam logic [1:0] SEL_PROG      = 2'h3;
   // Command codes.
   localparam logic [7:0] CMD_VFY_ALL   = 8'h01;
   localparam logic [7:0] CMD_VFY_BLK   = 8'h02;
   localparam logic [7:0] CMD_VFY_PSEC  = 8'h03;
   localparam logic [7:0] CMD_RD_ONCE   = 8'h04;
   localparam logic [7:0] CMD_PGM_P     = 8'h06;
   localparam logic [7:0] CMD_PGM_ONCE  = 8'h07;
   localparam logic [7:0] CMD_ERS_ALL   = 8'h08;
   localparam logic [7:0] CMD_ERS_BLK   = 8'h09;
   localparam logic [7:0] CMD_ERS_PSEC  = 8'h0A;
   localparam logic [7:0] CMD_UNSECURE  = 8'h0B;
   localparam logic [7:0] CMD_BACKDOOR  = 8'h0C;
   localparam logic [7:0] CMD_USR_MRG   = 8'h0D;
   localparam logic [7:0] CMD_FLD_MRG   = 8'h0E;
   localparam logic [7:0] CMD_VFY_DSEC  = 8'h10;
   localparam logic [7:0] CMD_PGM_D     = 8'h11;
   localparam logic [7:0] CMD_ERS_DSEC  = 8'h12;

   typedef enum logic [2:0] {
      CLS_NONE = 3'b000, CLS_READ = 3'b001, CLS_MARGIN = 3'b010,
      CLS_PROG = 3'b011, CLS_SECT = 3'b100, CLS_MASS = 3'b101
   } nvmcd_cls_t;
   typedef struct packed {
      nvmcd_cls_t pa;
      nvmcd_cls_t da;
   } nvmcd_pair_t;
   typedef struct packed {
      logic [7:0]  code;
      logic [1:0]  sel;
      logic [1:0]  wcnt;
      logic [15:0] param;
      nvmcd_pair_t cls;
   } nvmcd_op_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_LOCAL = 2'b10} nvmcd_state_t;

   // Command availability by special mode and secured state.
   function automatic logic cmd_valid(input logic [7:0] c, input logic ss, input logic sec);
      case (c)
         CMD_VFY_ALL, CMD_VFY_BLK: cmd_valid = 1'b1;
         CMD_ERS_ALL, CMD_UNSECURE: cmd_valid = ss;
         CMD_BACKDOOR: cmd_valid = !ss;
         CMD_FLD_MRG: cmd_valid = ss && !sec;
         CMD_VFY_PSEC, CMD_RD_ONCE, CMD_PGM_P, CMD_PGM_ONCE, CMD_ERS_BLK, CMD_ERS_PSEC,
         CMD_USR_MRG, CMD_VFY_DSEC, CMD_PGM_D, CMD_ERS_DSEC: cmd_valid = !(ss && sec);
         default: cmd_valid = 1'b0;
      endcase
   endfunction : cmd_valid

   // Array activity each command places on the two arrays.
   function automatic nvmcd_pair_t cmd_classes(input logic [7:0] c, input logic [1:0] s);
      cmd_classes = '{pa: CLS_NONE, da: CLS_NONE};
      case (c)
         CMD_VFY_ALL: cmd_classes = '{pa: CLS_READ, da: CLS_READ};
         CMD_VFY_BLK: begin
            if (s == SEL_PROG) cmd_classes.pa = CLS_READ;
            else cmd_classes.da = CLS_READ;
         end
         CMD_VFY_PSEC: cmd_classes.pa = CLS_READ;
         CMD_VFY_DSEC: cmd_classes.da = CLS_READ;
         CMD_RD_ONCE, CMD_BACKDOOR: cmd_classes.pa = CLS_READ;
         CMD_PGM_P, CMD_PGM_ONCE: cmd_classes.pa = CLS_PROG;
         CMD_ERS_ALL, CMD_UNSECURE: cmd_classes = '{pa: CLS_MASS, da: CLS_MASS};
         CMD_ERS_BLK: begin
            if (s == SEL_PROG) cmd_classes.pa = CLS_MASS;
            else cmd_classes.da = CLS_MASS;
         end
         CMD_ERS_PSEC: cmd_classes.pa = CLS_SECT;
         CMD_ERS_DSEC: cmd_classes.da = CLS_SECT;
         CMD_PGM_D: cmd_classes.da = CLS_PROG;
         default: cmd_classes = '{pa: CLS_NONE, da: CLS_NONE};
      endcase
   endfunction : cmd_classes

   // A read becomes a margin read once a non-normal level is in force.
   function automatic nvmcd_cls_t promote(input nvmcd_cls_t k, input logic mact);
      promote = (k == CLS_READ && mact) ? CLS_MARGIN : k;
   endfunction : promote

   // Permitted overlap of program-array and data-array activity.
   function automatic logic pair_ok(input nvmcd_cls_t pa, input nvmcd_cls_t da);
      pair_ok = (pa == CLS_NONE) || (da == CLS_NONE) ||
                (pa == CLS_READ && (da == CLS_MARGIN || da == CLS_PROG || da == CLS_SECT)) ||
                (pa == CLS_MASS && da == CLS_MASS);
   endfunction : pair_ok
endpackage : nvmcd_pkg

// *** logic/nvmcd_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous level inputs.
// Assumes the inputs are slow levels such as mode straps and security state.
`timescale 1ns/1ps
module nvmcd_sync #(
   parameter int W = 2
) (
   input  wire logic         core_clk_in, // Bus clock.
   input  wire logic         nrst_in,     // Asynchronous reset, active low.
   input  wire logic [W-1:0] async_in,    // Raw levels from outside the clock domain.
   output logic      [W-1:0] sync_out     // Filtered, synchronised levels.
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

   // A change is taken only when the second and third stages agree, so a metastable
   // first stage never reaches the output.
   always_comb begin
      filt_next = filt_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) filt_next[i] = s2_reg[i];
      end
   end

   // Stage registers.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
      end else begin
         s1_reg   <= async_in;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign sync_out = filt_reg;
endmodule : nvmcd_sync

// *** logic/nvmcd_dispatch.sv ***
// Command decoder and dispatcher: APB register file, launch checks, array
// engine handshake and arbitration of overlapping array reads.
// Assumes an array engine that takes op_start_out and answers with op_done_in.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module nvmcd_dispatch (
   input  wire logic             core_clk_in,        // Bus clock, 10 MHz.
   input  wire logic             nrst_in,            // Asynchronous reset, active low.
   input  wire logic             psel_in,            // APB select.
   input  wire logic             penable_in,         // APB enable.
   input  wire logic             pwrite_in,          // APB direction, high for write.
   input  wire logic [7:0]       paddr_in,           // APB byte address.
   input  wire logic [31:0]      pwdata_in,          // APB write data.
   output logic      [31:0]      prdata_out,         // APB read data.
   output logic                  pready_out,         // APB ready.
   output logic                  pslverr_out,        // APB error on unmapped address.
   input  wire logic             special_mode_input_in, // Special mode level, asynchronous.
   input  wire logic             secure_state_in,    // Secured state level, asynchronous.
   input  wire logic             once_locked_in,     // Information field already programmed.
   output logic                  op_start_out,       // One-cycle start for the array engine.
   output nvmcd_pkg::nvmcd_op_t  op_out,             // Operation held while running.
   input  wire logic             op_done_in,         // Engine finished, one-cycle pulse.
   input  wire logic             op_fail_in,         // Verify failure, valid with done.
   input  wire logic             pa_read_req_in,     // Program-array read request.
   output logic                  pa_read_grant_out,  // Program-array read allowed.
   input  wire logic             da_read_req_in,     // Data-array read request.
   output logic                  da_read_grant_out,  // Data-array read allowed.
   output logic      [1:0]       margin_level_out    // Margin level applied to reads.
);
   nvmcd_pkg::nvmcd_state_t state_reg, state_next;
   nvmcd_pkg::nvmcd_op_t    op_reg, op_next;
   logic [31:0] cmd_reg, cmd_next, rdata_reg, rdata_next;
   logic [3:0]  prot_reg, prot_next;
   logic [1:0]  margin_reg, margin_next, mode_sync;
   logic        command_complete_flag_reg, command_complete_flag_next, access_error_flag_reg, access_error_flag_next;
   logic        pviol_reg, pviol_next, vfail_reg, vfail_next;
   logic        start_reg, start_next;
   logic        wr_acc, mapped, launch, valid, par_err, once_err, prot_err, conflict, launch_ok;
   logic        mact;
   logic [7:0]  code;
   logic [1:0]  sel;
   nvmcd_pkg::nvmcd_pair_t cls;
   nvmcd_pkg::nvmcd_cls_t  ext_pa, ext_da, run_pa, run_da;

   // Mode and security arrive from outside the bus clock domain.
   nvmcd_sync #(.W(2)) u_sync (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .async_in    ({special_mode_input_in, secure_state_in}),
      .sync_out    (mode_sync)
   );

   // APB decode; the slave never inserts wait states.
   assign mapped = (paddr_in == nvmcd_pkg::REG_CMD) || (paddr_in == nvmcd_pkg::REG_STAT) ||
                   (paddr_in == nvmcd_pkg::REG_PROT) || (paddr_in == nvmcd_pkg::REG_MRG);
   assign wr_acc      = psel_in && penable_in && pwrite_in;
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out  = rdata_reg;

   // Decode of the loaded command and its launch checks.
   assign code = cmd_reg[nvmcd_pkg::CMD_CODE_LSB +: 8];
   assign sel  = cmd_reg[nvmcd_pkg::CMD_SEL_LSB +: 2];
   assign mact = (margin_reg != nvmcd_pkg::MARGIN_NORMAL);
   assign launch = wr_acc && (paddr_in == nvmcd_pkg::REG_STAT) && pwdata_in[nvmcd_pkg::STAT_COMMAND_COMPLETE_FLAG] &&
                   command_complete_flag_reg && !access_error_flag_reg && !pviol_reg;
   assign valid = nvmcd_pkg::cmd_valid(code, mode_sync[1], mode_sync[0]);
   assign par_err = (code == nvmcd_pkg::CMD_VFY_BLK || code == nvmcd_pkg::CMD_ERS_BLK) &&
                    sel != nvmcd_pkg::SEL_DATA && sel != nvmcd_pkg::SEL_PROG;
   assign once_err = (code == nvmcd_pkg::CMD_PGM_ONCE) && once_locked_in;

   // Erase-all and block erases need every relevant protection released beforehand.
   always_comb begin
      prot_err = 1'b0;
      if (code == nvmcd_pkg::CMD_ERS_ALL) begin
         prot_err = (prot_reg != nvmcd_pkg::PROT_ALL);
      end else if (code == nvmcd_pkg::CMD_ERS_BLK && sel == nvmcd_pkg::SEL_PROG) begin
         prot_err = ((prot_reg & nvmcd_pkg::PROT_PA_FREE) != nvmcd_pkg::PROT_PA_FREE);
      end else if (code == nvmcd_pkg::CMD_ERS_BLK && sel == nvmcd_pkg::SEL_DATA) begin
         prot_err = !prot_reg[nvmcd_pkg::PROT_DOPEN];
      end
   end

   // Array activity classes: the new command, outside reads and the running command.
   always_comb begin
      cls = nvmcd_pkg::cmd_classes(code, sel);
      cls.pa = nvmcd_pkg::promote(cls.pa, mact);
      cls.da = nvmcd_pkg::promote(cls.da, mact);
      ext_pa = pa_read_req_in ? nvmcd_pkg::promote(nvmcd_pkg::CLS_READ, mact) : nvmcd_pkg::CLS_NONE;
      ext_da = da_read_req_in ? nvmcd_pkg::promote(nvmcd_pkg::CLS_READ, mact) : nvmcd_pkg::CLS_NONE;
      run_pa = (state_reg == nvmcd_pkg::ST_RUN) ? op_reg.cls.pa : nvmcd_pkg::CLS_NONE;
      run_da = (state_reg == nvmcd_pkg::ST_RUN) ? op_reg.cls.da : nvmcd_pkg::CLS_NONE;
   end

   // A command that would collide with a read already asked of the other array is refused.
   assign conflict = !nvmcd_pkg::pair_ok(cls.pa, ext_da) || !nvmcd_pkg::pair_ok(ext_pa, cls.da);
   assign launch_ok = launch && valid && !par_err && !once_err && !prot_err && !conflict;

   // Program-array reads win a tie with data-array reads, giving read-while-write.
   assign pa_read_grant_out = pa_read_req_in && nvmcd_pkg::pair_ok(ext_pa, run_da);
   assign da_read_grant_out = da_read_req_in && nvmcd_pkg::pair_ok(run_pa, ext_da) &&
                              !(pa_read_req_in && !nvmcd_pkg::pair_ok(ext_pa, ext_da));
   assign margin_level_out = margin_reg;
   assign op_start_out = start_reg;
   assign op_out = op_reg;

   // Command sequencer and flags. Each flag set by hardware wins over a software clear
   // in the same cycle, so no event is lost.
   always_comb begin
      state_next  = state_reg;
      op_next     = op_reg;
      cmd_next    = cmd_reg;
      prot_next   = prot_reg;
      margin_next = margin_reg;
      command_complete_flag_next   = command_complete_flag_reg;
      vfail_next  = vfail_reg;
      start_next  = 1'b0;
      access_error_flag_next = access_error_flag_reg;
      pviol_next  = pviol_reg;
      if (wr_acc && paddr_in == nvmcd_pkg::REG_STAT) begin
         if (pwdata_in[nvmcd_pkg::STAT_ACCESS_ERROR_FLAG]) access_error_flag_next = 1'b0;
         if (pwdata_in[nvmcd_pkg::STAT_PVIOL]) pviol_next = 1'b0;
      end
      // Parameters are frozen while a command runs.
      if (wr_acc && paddr_in == nvmcd_pkg::REG_CMD && command_complete_flag_reg) cmd_next = pwdata_in;
      if (wr_acc && paddr_in == nvmcd_pkg::REG_PROT) prot_next = pwdata_in[3:0];
      case (state_reg)
         nvmcd_pkg::ST_IDLE: begin
            if (launch) begin
               if (!valid || par_err || once_err || conflict) begin
                  access_error_flag_next = 1'b1;
               end else if (prot_err) begin
                  pviol_next = 1'b1;
               end else begin
                  command_complete_flag_next  = 1'b0;
                  vfail_next = 1'b0;
                  op_next.code  = code;
                  op_next.sel   = sel;
                  op_next.wcnt  = cmd_reg[nvmcd_pkg::CMD_WCNT_LSB +: 2];
                  op_next.param = cmd_reg[nvmcd_pkg::CMD_PARAM_LSB +: 16];
                  op_next.cls   = cls;
                  if (code == nvmcd_pkg::CMD_USR_MRG || code == nvmcd_pkg::CMD_FLD_MRG) begin
                     state_next = nvmcd_pkg::ST_LOCAL;
                  end else begin
                     state_next = nvmcd_pkg::ST_RUN;
                     start_next = 1'b1;
                  end
               end
            end
         end
         nvmcd_pkg::ST_RUN: begin
            if (op_done_in) begin
               command_complete_flag_next  = 1'b1;
               vfail_next = op_fail_in;
               state_next = nvmcd_pkg::ST_IDLE;
            end
         end
         nvmcd_pkg::ST_LOCAL: begin
            margin_next = op_reg.sel;
            command_complete_flag_next   = 1'b1;
            state_next  = nvmcd_pkg::ST_IDLE;
         end
         default: state_next = nvmcd_pkg::ST_IDLE;
      endcase
   end

   // Sequencer and register state.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg  <= nvmcd_pkg::ST_IDLE;
         op_reg     <= '0;
         cmd_reg    <= '0;
         prot_reg   <= nvmcd_pkg::PROT_RST;
         margin_reg <= nvmcd_pkg::MARGIN_NORMAL;
         command_complete_flag_reg   <= 1'b1;
         access_error_flag_reg <= 1'b0;
         pviol_reg  <= 1'b0;
         vfail_reg  <= 1'b0;
         start_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         op_reg     <= op_next;
         cmd_reg    <= cmd_next;
         prot_reg   <= prot_next;
         margin_reg <= margin_next;
         command_complete_flag_reg   <= command_complete_flag_next;
         access_error_flag_reg <= access_error_flag_next;
         pviol_reg  <= pviol_next;
         vfail_reg  <= vfail_next;
         start_reg  <= start_next;
      end
   end

   // Read data is captured in the setup cycle so it is stable through the access cycle.
   always_comb begin
      rdata_next = rdata_reg;
      if (psel_in && !penable_in && !pwrite_in) begin
         rdata_next = 32'h0000_0000;
         if (paddr_in == nvmcd_pkg::REG_CMD) begin
            rdata_next = cmd_reg;
         end else if (paddr_in == nvmcd_pkg::REG_STAT) begin
            rdata_next[nvmcd_pkg::STAT_COMMAND_COMPLETE_FLAG]   = command_complete_flag_reg;
            rdata_next[nvmcd_pkg::STAT_ACCESS_ERROR_FLAG] = access_error_flag_reg;
            rdata_next[nvmcd_pkg::STAT_PVIOL]  = pviol_reg;
            rdata_next[nvmcd_pkg::STAT_VFAIL]  = vfail_reg;
         end else if (paddr_in == nvmcd_pkg::REG_PROT) begin
            rdata_next[3:0] = prot_reg;
         end else if (paddr_in == nvmcd_pkg::REG_MRG) begin
            rdata_next[1:0] = margin_reg;
            rdata_next[nvmcd_pkg::MRG_ACT] = mact;
            rdata_next[nvmcd_pkg::MRG_PA_LSB +: 3] = run_pa;
            rdata_next[nvmcd_pkg::MRG_DA_LSB +: 3] = run_da;
         end
      end
   end

   // Read data register.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) rdata_reg <= 32'h0000_0000;
      else rdata_reg <= rdata_next;
   end

   // Checks of the dispatcher's own behaviour.
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);

   unsupported_reject_a: assert property (launch && !valid |=> access_error_flag_reg && command_complete_flag_reg && !start_reg)
      else $error("Unsupported command was not refused.");
   launch_busy_a: assert property (launch_ok |=> !command_complete_flag_reg ##0 (state_reg != nvmcd_pkg::ST_IDLE))
      else $error("Accepted launch did not clear the complete flag.");
   done_sets_a: assert property ((state_reg == nvmcd_pkg::ST_RUN) && !op_done_in |=> !command_complete_flag_reg)
      else $error("Complete flag rose before the engine finished.");
   done_flag_a: assert property ((state_reg == nvmcd_pkg::ST_RUN) && op_done_in |=>
      command_complete_flag_reg && vfail_reg == $past(op_fail_in))
      else $error("Engine completion not reflected in status.");
   erase_all_prot_a: assert property (start_reg && op_reg.code == nvmcd_pkg::CMD_ERS_ALL |->
      $past(prot_reg) == nvmcd_pkg::PROT_ALL)
      else $error("Erase-all started without every protection released.");
   erase_blk_prot_a: assert property (start_reg && op_reg.code == nvmcd_pkg::CMD_ERS_BLK |->
      (op_reg.sel == nvmcd_pkg::SEL_PROG) ? ($past(prot_reg[2:0]) == 3'h7) :
      $past(prot_reg[nvmcd_pkg::PROT_DOPEN]))
      else $error("Block erase started with protection in force.");
   pa_read_pair_a: assert property (pa_read_grant_out && (state_reg == nvmcd_pkg::ST_RUN) &&
      (op_reg.cls.da != nvmcd_pkg::CLS_NONE) |->
      op_reg.cls.da inside {nvmcd_pkg::CLS_MARGIN, nvmcd_pkg::CLS_PROG, nvmcd_pkg::CLS_SECT})
      else $error("Program read granted beside a forbidden data operation.");
   read_pair_a: assert property (!(pa_read_grant_out && da_read_grant_out && !nvmcd_pkg::pair_ok(ext_pa, ext_da)))
      else $error("Two conflicting reads granted together.");
   margin_read_a: assert property (start_reg && (op_reg.cls.pa == nvmcd_pkg::CLS_READ) |->
      $past(margin_reg) == nvmcd_pkg::MARGIN_NORMAL)
      else $error("Read not marked as margin read.");
   field_margin_a: assert property ((state_reg == nvmcd_pkg::ST_LOCAL) &&
      op_reg.code == nvmcd_pkg::CMD_FLD_MRG |-> $past(mode_sync) == 2'b10)
      else $error("Field margin accepted outside special mode.");
   margin_set_a: assert property ((state_reg == nvmcd_pkg::ST_LOCAL) |=> margin_reg == $past(op_reg.sel) && command_complete_flag_reg)
      else $error("Margin command did not set the level.");
   once_only_a: assert property (launch && once_err |=> access_error_flag_reg && !start_reg)
      else $error("Second program-once was not refused.");
   conflict_a: assert property (launch && conflict |=> access_error_flag_reg && command_complete_flag_reg)
      else $error("Conflicting command was started.");

   launch_c: cover property (launch_ok ##1 start_reg ##[1:20] op_done_in);
   margin_c: cover property (launch_ok && code == nvmcd_pkg::CMD_USR_MRG);
   rww_c: cover property (pa_read_grant_out && op_reg.cls.da == nvmcd_pkg::CLS_PROG && state_reg == nvmcd_pkg::ST_RUN);
   prot_c: cover property (launch && prot_err);
endmodule : nvmcd_dispatch

// *** test/nvmcd_engine_model.sv ***
// Array engine model that answers each start pulse with a done pulse.
// Assumes the dispatcher clock and reset; the engine never reports a verify failure.
`timescale 1ns/1ps
module nvmcd_engine_model (
   input  wire logic core_clk_in,  // Bus clock.
   input  wire logic nrst_in,      // Asynchronous reset, active low.
   input  wire logic op_start_in,  // Start pulse from the dispatcher.
   output logic      op_done_out   // One-cycle done pulse.
);
   logic [2:0] busy_reg;
   // A fixed latency keeps the bench simple at the cost of never testing slow answers.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) busy_reg <= 3'h0;
      else if (op_start_in) busy_reg <= 3'h4;
      else if (busy_reg != 3'h0) busy_reg <= busy_reg - 3'h1;
   end
   assign op_done_out = (busy_reg == 3'h1);
endmodule : nvmcd_engine_model

// *** test/testbench.sv ***
// Self-checking bench: launches a table of commands over APB and checks the status word.
// Assumes the engine model answers starts; security and reads stay idle, mode and fail are driven.
`timescale 1ns/1ps
module testbench;
   logic core_clk_in = 0, nrst_in = 0, psel = 0, penable = 0, pwrite = 0, done, start;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic pready, pslverr, e, ss = 0, fail = 0;
   logic [1:0] mrg;
   int miscompares = 0, checks_done = 0, cyc = 0;
   typedef struct {logic [7:0] c; logic [1:0] s; logic [31:0] x;} nvmcd_row_t;
   nvmcd_row_t rows[11] = '{'{8'h01,2'h0,32'h80},'{8'h02,2'h3,32'h80},'{8'h02,2'h1,32'hA0},
      '{8'h06,2'h0,32'h80},'{8'h11,2'h0,32'h80},'{8'h0C,2'h0,32'h80},'{8'h08,2'h0,32'hA0},
      '{8'h09,2'h3,32'h90},'{8'h0E,2'h0,32'hA0},'{8'h05,2'h0,32'hA0},'{8'h12,2'h0,32'h80}};
   nvmcd_dispatch nvmcd_dispatch_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .special_mode_input_in(ss), .secure_state_in(1'b0),
      .once_locked_in(1'b0), .op_start_out(start), .op_out(), .op_done_in(done), .op_fail_in(fail),
      .pa_read_req_in(1'b0), .pa_read_grant_out(), .da_read_req_in(1'b0), .da_read_grant_out(),
      .margin_level_out(mrg));
   nvmcd_engine_model nvmcd_engine_model_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .op_start_in(start), .op_done_out(done));
   // Clock at 10 MHz; a hang is cut short by the cycle ceiling.
   initial forever #50 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (++cyc == 20000) begin miscompares++; results(); end
   // Setup cycle, then access phase held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge core_clk_in) penable <= 1;
      do @(posedge core_clk_in); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] v);
      checks_done++;
      if (v !== x) begin miscompares++; $display("FAIL %s expected %h seen %h", n, x, v); end
   endtask : chk
   // Launch, poll until complete, report status, then clear the error flags.
   task automatic run(input logic [7:0] c, input logic [1:0] s, input logic [31:0] x);
      apb(1, 8'h00, {22'h0, s, c});
      apb(1, 8'h04, 32'h0000_0080);
      repeat (40) begin apb(0, 8'h04, 32'h0); if (r[7] === 1'b1) break; end
      chk("status", x, r);
      apb(1, 8'h04, 32'h0000_0030);
   endtask : run
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   // Reset checks, the command table, then protection, margin and unmapped cases.
   initial begin
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1;
      apb(0, 8'h04, 32'h0); chk("stat_rst", 32'h0000_0080, r);
      apb(0, 8'h08, 32'h0); chk("prot_rst", 32'h0000_0000, r);
      foreach (rows[i]) run(rows[i].c, rows[i].s, rows[i].x);
      $display("table done");
      apb(1, 8'h08, 32'h0000_000F);
      run(8'h09, 2'h3, 32'h80);
      run(8'h09, 2'h0, 32'h80);
      run(8'h08, 2'h0, 32'hA0);
      $display("protection done");
      // Special mode needs several cycles to pass the synchroniser before commands see it.
      ss <= 1;
      repeat (8) @(posedge core_clk_in);
      apb(1, 8'h08, 32'h0000_0007);
      run(8'h08, 2'h0, 32'h90);
      apb(1, 8'h08, 32'h0000_000F);
      run(8'h08, 2'h0, 32'h80);
      run(8'h0B, 2'h0, 32'h80);
      run(8'h0E, 2'h1, 32'h80);
      chk("field_margin", 32'h1, {30'h0, mrg});
      ss <= 0;
      fail <= 1;
      run(8'h01, 2'h0, 32'h81);
      fail <= 0;
      $display("special mode done");
      run(8'h0D, 2'h2, 32'h80); chk("margin", 32'h2, {30'h0, mrg});
      apb(0, 8'h0C, 32'h0); chk("margin_act", 32'h1, {31'h0, r[2]});
      apb(0, 8'h10, 32'h0); chk("unmapped", 32'h1, {31'h0, e});
      $display("margin and unmapped done");
      // A reset while idle must bring status, protection and margin back to reset values.
      nrst_in <= 0;
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1;
      apb(0, 8'h04, 32'h0);
      chk("stat_rst2", 32'h0000_0080, r);
      apb(0, 8'h08, 32'h0);
      chk("prot_rst2", 32'h0000_0000, r);
      chk("margin_rst", 32'h0, {30'h0, mrg});
      $display("reset done");
      results();
   end
endmodule : testbench
